// ---- rat_top.sv ----
`timescale 1ns/10ps
module rat_top #(
  parameter logic [16:0] REF_LOST_CYC = rat_pkg::REF_LOST_CYC
) (
  // Clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Clocks under measurement
  input  wire logic        ref_clk_i,
  input  wire logic        rc_clk_i,
  // Trim and interrupt
  output logic [8:0]       trim_value_o,
  output logic             irq_o
);

  rat_pkg::rat_top_st_t st;
  rat_pkg::rat_top_st_t nx;
  rat_meas_if           mi ();

  logic        req;
  logic        wr;
  logic        hit_ctl;
  logic        hit_ien;
  logic        hit_sts;
  logic [31:0] wmask;
  logic [31:0] ctl_rd;
  logic [31:0] ien_rd;
  logic [31:0] sts_rd;
  logic [31:0] ctl_wr;
  logic [31:0] w1c;
  logic [9:0]  limit;
  logic        enabled;
  logic        locked;
  logic        clk_err;
  logic        over_bound;
  logic [8:0]  trim_next;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement and step decision

  assign mi.run     = st.run;
  assign mi.win_sel = st.avg_sel;

  rat_ref_meter #(
    .LOST_CYC (REF_LOST_CYC)
  ) u_meter (
    .clk_i     (clk_i),
    .rst_i     (rst_i | por_i),
    .ref_clk_i (ref_clk_i),
    .rc_clk_i  (rc_clk_i),
    .mi        (mi.meter)
  );

  rat_trim_step u_step (
    .count_i      (st.count),
    .win_sel_i    (st.avg_sel),
    .trim_i       (st.trim),
    .range_en_i   (st.range_en),
    .bound_i      (st.bound),
    .locked_o     (locked),
    .clk_err_o    (clk_err),
    .over_bound_o (over_bound),
    .trim_next_o  (trim_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign req     = wb_cyc_i & wb_stb_i;
  assign wr      = req & st.ack & wb_we_i;
  assign hit_ctl = (wb_adr_i[7:2] == rat_pkg::TRIM_CTL_OFF[7:2]);
  assign hit_ien = (wb_adr_i[7:2] == rat_pkg::TRIM_IEN_OFF[7:2]);
  assign hit_sts = (wb_adr_i[7:2] == rat_pkg::TRIM_STS_OFF[7:2]);
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ctl_wr  = (ctl_rd & ~wmask) | (wb_dat_i & wmask);
  assign w1c     = (wr && hit_sts) ? (wb_dat_i & wmask) : 32'h0000_0000;

  assign limit = (st.limit_sel == 2'h0) ? rat_pkg::LIMIT_64 :
                 (st.limit_sel == 2'h1) ? rat_pkg::LIMIT_256 : rat_pkg::LIMIT_512;

  always_comb begin
    ctl_rd = 32'h0000_0000;
    ctl_rd[rat_pkg::TSEL_LSB +: 2]  = st.tsel;
    ctl_rd[rat_pkg::AVG_LSB +: 2]   = st.avg_sel;
    ctl_rd[rat_pkg::LIMIT_LSB +: 2] = st.limit_sel;
    ctl_rd[rat_pkg::HALT_BIT]       = st.halt;
    ctl_rd[rat_pkg::RANGE_EN_BIT]   = st.range_en;
    ctl_rd[rat_pkg::REF_SEL_BIT]    = st.ref_sel;
    ctl_rd[rat_pkg::BOUND_LSB +: 5] = st.bound;
    ien_rd = 32'h0000_0000;
    ien_rd[rat_pkg::FAIL_IEN_BIT]   = st.ien_fail;
    ien_rd[rat_pkg::CLKERR_IEN_BIT] = st.ien_clkerr;
    sts_rd = 32'h0000_0000;
    sts_rd[rat_pkg::LOCK_BIT]       = st.f_lock;
    sts_rd[rat_pkg::FAIL_BIT]       = st.f_fail;
    sts_rd[rat_pkg::CLKERR_BIT]     = st.f_clkerr;
    sts_rd[rat_pkg::OVB_BIT]        = st.f_ovb;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nx     = st;
    nx.ack = 1'b0;
    if (req && !st.ack) begin
      nx.ack = 1'b1;
      nx.dat = hit_ctl ? ctl_rd : hit_ien ? ien_rd : hit_sts ? sts_rd : 32'h0000_0000;
    end
    if (wr && hit_ctl) begin
      nx.tsel      = ctl_wr[rat_pkg::TSEL_LSB +: 2];
      nx.avg_sel   = ctl_wr[rat_pkg::AVG_LSB +: 2];
      nx.limit_sel = ctl_wr[rat_pkg::LIMIT_LSB +: 2];
      nx.halt      = ctl_wr[rat_pkg::HALT_BIT];
      nx.range_en  = ctl_wr[rat_pkg::RANGE_EN_BIT];
      nx.ref_sel   = ctl_wr[rat_pkg::REF_SEL_BIT];
      nx.bound     = ctl_wr[rat_pkg::BOUND_LSB +: 5];
    end
    if (wr && hit_ien) begin
      nx.ien_fail   = wb_dat_i[rat_pkg::FAIL_IEN_BIT] & wb_sel_i[0];
      nx.ien_clkerr = wb_dat_i[rat_pkg::CLKERR_IEN_BIT] & wb_sel_i[0];
    end
    nx.f_lock   = st.f_lock & ~w1c[rat_pkg::LOCK_BIT];
    nx.f_fail   = st.f_fail & ~w1c[rat_pkg::FAIL_BIT];
    nx.f_clkerr = st.f_clkerr & ~w1c[rat_pkg::CLKERR_BIT];
    nx.f_ovb    = st.f_ovb & ~w1c[rat_pkg::OVB_BIT];
    enabled = (nx.tsel == rat_pkg::TSEL_48M) && !nx.ref_sel;
    case (st.state)
      rat_pkg::RAT_IDLE: begin
        if (enabled) begin
          nx.attempts = 10'h000;
          nx.run      = 1'b1;
          nx.state    = rat_pkg::RAT_RUN;
        end
      end
      rat_pkg::RAT_RUN: begin
        if (!enabled) begin
          nx.run   = 1'b0;
          nx.state = rat_pkg::RAT_IDLE;
        end else if (mi.lost) begin
          nx.f_clkerr = 1'b1;
        end else if (mi.done) begin
          nx.count = mi.count;
          nx.state = rat_pkg::RAT_EVAL;
        end
      end
      rat_pkg::RAT_EVAL: begin
        nx.state = rat_pkg::RAT_RUN;
        if (!enabled) begin
          nx.run   = 1'b0;
          nx.state = rat_pkg::RAT_IDLE;
        end else if (clk_err) begin
          nx.f_clkerr = 1'b1;
          if (st.halt) begin
            nx.tsel  = rat_pkg::TSEL_OFF;
            nx.run   = 1'b0;
            nx.state = rat_pkg::RAT_IDLE;
          end
        end else if (locked) begin
          nx.f_lock   = 1'b1;
          nx.attempts = 10'h000;
        end else begin
          nx.f_ovb    = nx.f_ovb | over_bound;
          nx.trim     = trim_next;
          nx.attempts = st.attempts + 10'h001;
          if (st.attempts + 10'h001 == limit) begin
            nx.f_fail = 1'b1;
            nx.tsel   = rat_pkg::TSEL_OFF;
            nx.run    = 1'b0;
            nx.state  = rat_pkg::RAT_IDLE;
          end
        end
      end
      default: begin
        nx.run   = 1'b0;
        nx.state = rat_pkg::RAT_IDLE;
      end
    endcase
    nx.irq = (nx.f_clkerr & nx.ien_clkerr) | (nx.f_fail & nx.ien_fail);
    if (rst_i || por_i) begin
      nx       = '0;
      nx.state = rat_pkg::RAT_IDLE;
      nx.bound = rat_pkg::BOUND_RST;
      nx.trim  = rat_pkg::TRIM_INIT;
      if (!por_i) begin
        nx.f_lock   = st.f_lock;
        nx.f_fail   = st.f_fail;
        nx.f_clkerr = st.f_clkerr;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    st <= nx;
  end

  assign wb_dat_o     = st.dat;
  assign wb_ack_o     = st.ack;
  assign trim_value_o = st.trim;
  assign irq_o        = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);

  sequence s_fail_eval;
    st.state == rat_pkg::RAT_EVAL && (st.tsel == rat_pkg::TSEL_48M) && !st.ref_sel && !wr
      && !clk_err && !locked && (st.attempts + 10'h001 == limit);
  endsequence

  sequence s_stopped;
    (st.f_fail && st.tsel == rat_pkg::TSEL_OFF && !st.run) ##1 (st.state == rat_pkg::RAT_IDLE);
  endsequence

  a_ack_single_pulse: assert property (st.ack |=> !st.ack)
    else $error("ack held longer than one cycle");

  a_reserved_select_stops: assert property (
    (st.state == rat_pkg::RAT_RUN && st.tsel != rat_pkg::TSEL_48M) |=> st.state == rat_pkg::RAT_IDLE)
    else $error("trim kept running with select not 01");

  a_eval_after_done: assert property (
    st.state == rat_pkg::RAT_EVAL |-> $past(mi.done) && st.count == $past(mi.count))
    else $error("evaluation without a finished window");

  a_lock_clears_attempts: assert property (
    (st.state == rat_pkg::RAT_EVAL && st.tsel == rat_pkg::TSEL_48M && !st.ref_sel && !wr
      && !clk_err && locked) |=> (st.attempts == 10'h000 && st.f_lock))
    else $error("lock did not clear attempt counter");

  a_limit_stops_trim: assert property (s_fail_eval |=> s_stopped)
    else $error("retry limit did not stop trimming");

  a_clock_error_halt: assert property (
    (st.state == rat_pkg::RAT_EVAL && st.tsel == rat_pkg::TSEL_48M && !st.ref_sel && !wr
      && clk_err) |=> (st.f_clkerr && (st.tsel == rat_pkg::TSEL_OFF) == $past(st.halt)))
    else $error("clock error handling wrong");

  a_ref_lost_flags: assert property (
    (st.state == rat_pkg::RAT_RUN && st.tsel == rat_pkg::TSEL_48M && !st.ref_sel && !wr
      && mi.lost) |=> st.f_clkerr)
    else $error("missing reference not flagged");

  a_ovb_needs_range: assert property ($rose(st.f_ovb) |-> $past(st.range_en))
    else $error("over-boundary flagged without range check");

  a_irq_from_flags: assert property (
    st.irq == ((st.f_clkerr && st.ien_clkerr) || (st.f_fail && st.ien_fail)))
    else $error("interrupt does not follow flags and enables");

  a_fail_w1c: assert property (
    (wr && hit_sts && wb_sel_i[0] && wb_dat_i[rat_pkg::FAIL_BIT]
      && st.state != rat_pkg::RAT_EVAL) |=> !st.f_fail)
    else $error("trim fail flag not cleared by write one");

  a_lock_no_irq: assert property (
    ($rose(st.f_lock) && !st.f_fail && !st.f_clkerr) |-> !st.irq)
    else $error("lock flag raised an interrupt");

  a_flags_keep_reset: assert property (@(posedge clk_i) disable iff (por_i)
    rst_i |=> (st.f_fail == $past(st.f_fail) && st.f_clkerr == $past(st.f_clkerr)))
    else $error("flag lost on non power-on reset");

  a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !st.ack) |=> st.ack)
    else $error("request not acknowledged in the next cycle");

  a_trim_eval_only: assert property (
    (!$stable(st.trim) && !$past(rst_i) && !$past(por_i))
      |-> $past(st.state) == rat_pkg::RAT_EVAL)
    else $error("trim changed outside an evaluation");

  a_ovb_holds_trim: assert property ($rose(st.f_ovb) |-> $stable(st.trim))
    else $error("trim moved on an over-boundary step");

endmodule

// ---- rat_pkg.sv ----
// Operation
// - Target select 00 disables trimming, 01 trims toward 48 MHz, others reserved.
// - Error is averaged over 4, 8, 16 or 32 reference periods.
// - Update attempts before lock limited to 64, 256 or 512 loops.
// - Lock clears the update attempt counter to zero.
// - Reaching the limit without lock stops trimming, clears select, sets fail flag.
// - Unreasonable ratio sets clock error; halt bit also stops trimming and clears select.
// - Enabling trim without the crystal reference sets the clock error flag.
// - Reference select 0 uses the crystal clock; 1 is reserved.
// - Boundary range 0x1 to 0x1F applies only while range check is enabled.
// - Range check enabled: over-boundary sets its flag; writing 1 clears it.
// - Clock error flag with its enable set raises the interrupt.
// - Trim fail flag with its enable set raises the interrupt.
// - Trim fail flag sets at the limit without lock; writing 1 clears it.
// - Lock flag sets when enabled and locked; write 1 clears; never interrupts.
// - Fail, clock error and lock flags are cleared by power-on reset, not by system reset.
package rat_pkg;

  // Register offsets
  localparam logic [7:0]  TRIM_CTL_OFF   = 8'hF0;
  localparam logic [7:0]  TRIM_IEN_OFF   = 8'hF4;
  localparam logic [7:0]  TRIM_STS_OFF   = 8'hF8;
  localparam logic [31:0] TRIM_CTL_RST   = 32'h0008_0000;

  // Field positions
  localparam int          TSEL_LSB       = 0;
  localparam int          AVG_LSB        = 4;
  localparam int          LIMIT_LSB      = 6;
  localparam int          HALT_BIT       = 8;
  localparam int          RANGE_EN_BIT   = 9;
  localparam int          REF_SEL_BIT    = 10;
  localparam int          BOUND_LSB      = 16;
  localparam int          FAIL_IEN_BIT   = 1;
  localparam int          CLKERR_IEN_BIT = 2;
  localparam int          LOCK_BIT       = 0;
  localparam int          FAIL_BIT       = 1;
  localparam int          CLKERR_BIT     = 2;
  localparam int          OVB_BIT        = 3;

  // Field codes and reset values
  localparam logic [1:0]  TSEL_OFF       = 2'h0;
  localparam logic [1:0]  TSEL_48M       = 2'h1;
  localparam logic [4:0]  BOUND_RST      = 5'h08;
  localparam logic [9:0]  LIMIT_64       = 10'h040;
  localparam logic [9:0]  LIMIT_256      = 10'h100;
  localparam logic [9:0]  LIMIT_512      = 10'h200;
  localparam logic [8:0]  TRIM_INIT      = 9'h100;

  // Measurement figures, scaled to a 32 period window
  localparam logic [16:0] TARGET_32      = 17'h0B71B;
  localparam logic [20:0] LOCK_TOL       = 21'h00010;
  localparam logic [20:0] ERR_LIMIT      = 21'h02DC6;

  // Timing
  localparam int          CLK_MHZ        = 250;
  localparam int          REF_LOST_NS    = 61036;
  localparam logic [16:0] REF_LOST_CYC   = 17'((REF_LOST_NS * CLK_MHZ) / 1000);

  typedef enum logic [1:0] {
    RAT_IDLE = 2'h0,
    RAT_RUN  = 2'h1,
    RAT_EVAL = 2'h3
  } rat_state_t;

  typedef struct packed {
    logic        ref_d;
    logic        rc_d;
    logic        started;
    logic [5:0]  periods;
    logic [16:0] cnt;
    logic [16:0] idle;
    logic        done;
    logic        lost;
    logic [16:0] count;
  } rat_meter_st_t;

  typedef struct packed {
    rat_state_t  state;
    logic [1:0]  tsel;
    logic [1:0]  avg_sel;
    logic [1:0]  limit_sel;
    logic        halt;
    logic        range_en;
    logic        ref_sel;
    logic [4:0]  bound;
    logic        ien_clkerr;
    logic        ien_fail;
    logic        f_lock;
    logic        f_fail;
    logic        f_clkerr;
    logic        f_ovb;
    logic [9:0]  attempts;
    logic [8:0]  trim;
    logic [16:0] count;
    logic        run;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
  } rat_top_st_t;

endpackage

// ---- rat_meas_if.sv ----
`timescale 1ns/10ps
interface rat_meas_if;
  logic        run;
  logic [1:0]  win_sel;
  logic        done;
  logic [16:0] count;
  logic        lost;
  modport ctrl  (output run, win_sel, input done, count, lost);
  modport meter (input run, win_sel, output done, count, lost);
endinterface

// ---- rat_ref_meter.sv ----
`timescale 1ns/10ps
module rat_ref_meter #(
  parameter logic [16:0] LOST_CYC = rat_pkg::REF_LOST_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Clocks under measurement
  input  wire logic       ref_clk_i,
  input  wire logic       rc_clk_i,
  // Control side
  rat_meas_if.meter       mi
);

  rat_pkg::rat_meter_st_t st;
  rat_pkg::rat_meter_st_t nx;
  logic                   ref_rise;
  logic                   rc_rise;
  logic [5:0]             win_len;

  assign ref_rise = ref_clk_i & ~st.ref_d;
  assign rc_rise  = rc_clk_i & ~st.rc_d;
  assign win_len  = 6'(6'h04 << mi.win_sel);
  assign mi.done  = st.done;
  assign mi.count = st.count;
  assign mi.lost  = st.lost;

  always_comb begin
    nx       = st;
    nx.ref_d = ref_clk_i;
    nx.rc_d  = rc_clk_i;
    nx.done  = 1'b0;
    nx.lost  = 1'b0;
    if (!mi.run) begin
      nx.started = 1'b0;
      nx.periods = 6'h00;
      nx.cnt     = 17'h00000;
      nx.idle    = 17'h00000;
    end else begin
      if (rc_rise && st.cnt != 17'h1FFFF) begin
        nx.cnt = st.cnt + 17'h00001;
      end
      if (ref_rise) begin
        nx.idle = 17'h00000;
        if (!st.started) begin
          nx.started = 1'b1;
          nx.cnt     = 17'h00000;
        end else if (st.periods + 6'h01 == win_len) begin
          nx.periods = 6'h00;
          nx.done    = 1'b1;
          nx.count   = nx.cnt;
          nx.cnt     = 17'h00000;
        end else begin
          nx.periods = st.periods + 6'h01;
        end
      end else if (st.idle == LOST_CYC - 17'h00001) begin
        nx.idle    = 17'h00000;
        nx.lost    = 1'b1;
        nx.started = 1'b0;
        nx.periods = 6'h00;
      end else begin
        nx.idle = st.idle + 17'h00001;
      end
    end
    if (rst_i) begin
      nx = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= nx;
  end

endmodule

// ---- rat_trim_step.sv ----
`timescale 1ns/10ps
module rat_trim_step (
  // Measurement
  input  wire logic [16:0] count_i,
  input  wire logic [1:0]  win_sel_i,
  // Trim and range
  input  wire logic [8:0]  trim_i,
  input  wire logic        range_en_i,
  input  wire logic [4:0]  bound_i,
  // Decision
  output logic             locked_o,
  output logic             clk_err_o,
  output logic             over_bound_o,
  output logic [8:0]       trim_next_o
);

  logic [19:0] norm;
  logic [20:0] err;
  logic [20:0] mag;
  logic [9:0]  cand;
  logic [9:0]  lo;
  logic [9:0]  hi;

  // scale to a 32 period window
  assign norm = 20'({count_i, 3'h0} >> win_sel_i);
  assign err  = {1'b0, norm} - {4'h0, rat_pkg::TARGET_32};
  assign mag  = err[20] ? (~err + 21'h000001) : err;

  assign locked_o  = (mag <= rat_pkg::LOCK_TOL);
  assign clk_err_o = (mag > rat_pkg::ERR_LIMIT);

  assign cand = err[20] ? ({1'b0, trim_i} + 10'h001) : ({1'b0, trim_i} - 10'h001);
  assign lo   = {1'b0, rat_pkg::TRIM_INIT} - {5'h00, bound_i};
  assign hi   = {1'b0, rat_pkg::TRIM_INIT} + {5'h00, bound_i};

  assign over_bound_o = range_en_i & ((cand < lo) | (cand > hi));
  assign trim_next_o  = (over_bound_o | cand[9]) ? trim_i : cand[8:0];

endmodule

// ---- rat_xtal_model.sv ----
`timescale 1ns/10ps
module rat_xtal_model (
  // Trim feedback from the block
  input  wire logic [8:0]  trim_i,
  // Bench control
  input  wire logic        ref_on_i,
  input  wire logic [11:0] base_i,
  // Clocks seen by the block
  output logic             ref_clk_o,
  output logic             rc_clk_o
);
  // Oscillator periods per reference period grow by this per trim step
  localparam int HIGH_CNT = 730;
  localparam int STEP     = 5;

  int            low_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator, edges kept off the block clock edges
  initial begin
    rc_clk_o = 1'b0;
    #1;
    forever #6 rc_clk_o = ~rc_clk_o;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // crystal reference source
  // reference stops when switched off
  // Low phase sized from the trim that is current mid-period
  initial begin
    ref_clk_o = 1'b0;
    forever begin
      wait (ref_on_i === 1'b1);
      ref_clk_o = 1'b1;
      repeat (HIGH_CNT) @(posedge rc_clk_o);
      ref_clk_o = 1'b0;
      low_cnt = int'(base_i) + STEP * (int'(trim_i) - 256) - HIGH_CNT;
      if (low_cnt < 1) begin
        low_cnt = 1;
      end
      repeat (low_cnt) @(posedge rc_clk_o);
    end
  end
endmodule

// ---- rc_oscillator_auto_trim_tb_top.sv ----
`timescale 1ns/10ps
module rc_oscillator_auto_trim_tb_top;
  localparam logic [16:0] LOST_CYC = 17'h01770;
  localparam logic [7:0]  CTL      = rat_pkg::TRIM_CTL_OFF;
  localparam logic [7:0]  IEN      = rat_pkg::TRIM_IEN_OFF;
  localparam logic [7:0]  STS      = rat_pkg::TRIM_STS_OFF;

  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        por_i     = 1'b1;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ref_clk;
  logic        rc_clk;
  logic [8:0]  trim_value_o;
  logic        irq_o;
  logic        ref_on    = 1'b0;
  logic [11:0] base_cnt  = 12'h5AF;
  logic [31:0] rd;
  logic [31:0] wd;
  int          seed      = 50086;
  int          err_total = 0;
  int          tests_run = 0;

  always #2 clk_i = ~clk_i;

  rat_top #(.REF_LOST_CYC(LOST_CYC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_clk_i(ref_clk), .rc_clk_i(rc_clk),
    .trim_value_o(trim_value_o), .irq_o(irq_o)
  );

  rat_xtal_model xtal (
    .trim_i(trim_value_o), .ref_on_i(ref_on), .base_i(base_cnt),
    .ref_clk_o(ref_clk), .rc_clk_o(rc_clk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pins looked at mid-cycle, back on a rising edge after
  task automatic chk_pin(input logic [8:0] exp, input logic sel_irq);
    logic [8:0] got;
    @(negedge clk_i);
    got = sel_irq ? {8'h00, irq_o} : trim_value_o;
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
    @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1)
      err_total++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb_xfer(1'b0, a, 32'h0, r);
    chk_reg(r, exp);
  endtask

  task automatic wait_bit(input int b);
    logic [31:0] s;
    int          n;
    s = 32'h0;
    n = 0;
    while (s[b] !== 1'b1 && n < 20000) begin
      wb_xfer(1'b0, STS, 32'h0, s);
      n++;
    end
    if (s[b] !== 1'b1)
      err_total++;
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] tsel, input logic [1:0] avg,
                                      input logic halt, input logic ren, input logic [4:0] bnd);
    logic [31:0] v;
    v = 32'h0;
    v[rat_pkg::TSEL_LSB +: 2]  = tsel;
    v[rat_pkg::AVG_LSB +: 2]   = avg;
    v[rat_pkg::HALT_BIT]       = halt;
    v[rat_pkg::RANGE_EN_BIT]   = ren;
    v[rat_pkg::BOUND_LSB +: 5] = bnd;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(CTL, rat_pkg::TRIM_CTL_RST);
    rd_chk(IEN, 32'h0);
    rd_chk(STS, 32'h0);
    chk_pin(rat_pkg::TRIM_INIT, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wd = $random(seed);
      wd[rat_pkg::REF_SEL_BIT] = 1'b1;
      wr(CTL, wd);
      rd_chk(CTL, wd & 32'h001F07F3);
      wd = $random(seed);
      wr(IEN, wd);
      rd_chk(IEN, wd & 32'h00000006);
      wr(8'h10, wd);
      rd_chk(8'h10, 32'h0);
      wr(STS, wd);
      rd_chk(STS, 32'h0);
    end
    // Slow oscillator, one step allowed, then blocked at the boundary
    wr(IEN, 32'h6);
    ref_on <= 1'b1;
    wr(CTL, ctl(2'h1, 2'h0, 1'b0, 1'b1, 5'h01));
    wait_bit(rat_pkg::OVB_BIT);
    base_cnt <= 12'h5B4;
    chk_pin(9'h101, 1'b0);
    rd_chk(STS, 32'h8);
    wr(STS, 32'h8);
    rd_chk(STS, 32'h0);
    wait_bit(rat_pkg::LOCK_BIT);
    chk_pin(9'h101, 1'b0);
    chk_pin(9'h000, 1'b1);
    wr(STS, 32'h1);
    wb_xfer(1'b0, STS, 32'h0, rd);
    chk_reg(rd & 32'h1, 32'h0);
    // Ratio far off with halt set
    wr(CTL, ctl(2'h0, 2'h0, 1'b0, 1'b0, 5'h08));
    base_cnt <= 12'h2BC;
    wr(CTL, ctl(2'h1, 2'h1, 1'b1, 1'b0, 5'h08));
    wait_bit(rat_pkg::CLKERR_BIT);
    rd_chk(CTL, ctl(2'h0, 2'h1, 1'b1, 1'b0, 5'h08));
    chk_pin(9'h001, 1'b1);
    wr(IEN, 32'h2);
    chk_pin(9'h000, 1'b1);
    wr(STS, 32'h4);
    rd_chk(STS, 32'h0);
    // Reference lost while trimming, halt clear
    ref_on <= 1'b0;
    wr(CTL, ctl(2'h1, 2'h0, 1'b0, 1'b0, 5'h08));
    wait_bit(rat_pkg::CLKERR_BIT);
    rd_chk(CTL, ctl(2'h1, 2'h0, 1'b0, 1'b0, 5'h08));
    chk_pin(9'h000, 1'b1);
    // System reset keeps flags, power-on reset clears them
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(STS, 32'h4);
    rd_chk(CTL, rat_pkg::TRIM_CTL_RST);
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(STS, 32'h0);
    finish_test();
  end
endmodule
